// [include/scc_pkg.sv]
// Shared constants and types for the security-context cache controller.
package scc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_PTR = 5'h04;
    localparam logic [4:0] OFS_ID = 5'h08;
    localparam logic [4:0] OFS_MISS = 5'h0C;
    localparam logic [4:0] OFS_FLOW1 = 5'h10;
    localparam logic [4:0] OFS_FLOW0 = 5'h14;
    localparam logic [4:0] OFS_ENG1 = 5'h18;
    localparam logic [4:0] OFS_ENG0 = 5'h1C;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int CTRL_BUSY_BIT = 31;
    localparam int CTRL_CNT_LSB = 24;
    localparam int CTRL_STATS_BIT = 4;
    localparam int CTRL_P0EN_BIT = 3;
    localparam int CTRL_P1EN_BIT = 2;
    localparam int CTRL_FLUSH_BIT = 1;
    localparam int CTRL_AUTO_BIT = 0;
    localparam int ID_DONE_BIT = 31;
    localparam int ID_ERR_LSB = 28;
    localparam int ID_RAM_LSB = 20;
    localparam int ID_GO_BIT = 19;
    localparam int ID_TEAR_BIT = 17;
    localparam int ID_EVICT_BIT = 16;
    localparam int CNT_W = 7;
    localparam int FLOW_W = 8;
    localparam int ENG_W = 5;
    localparam int SCID_W = 16;
    localparam int RAMIDX_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic RST_P0EN = 1'h1;
    localparam logic RST_P1EN = 1'h1;
    localparam logic RST_AUTO = 1'h1;
    localparam logic [31:0] RST_PTR = 32'h0000_0000;
    localparam logic [7:0] RST_FLOW = 8'h00;
    localparam logic [4:0] RST_ENG1 = 5'h00;
    localparam logic [4:0] RST_ENG0 = 5'h08;

    ////////////////////////////////////////////////////////////////////////////
    // Fetch error codes.
    localparam logic [2:0] ERR_OK = 3'h0;
    localparam logic [2:0] ERR_EVICT_MISS = 3'h2;
    localparam logic [2:0] ERR_TEAR_MISS = 3'h3;
    localparam logic [2:0] ERR_OWNER = 3'h4;
    localparam logic [2:0] ERR_NO_AUTO = 3'h6;

    // Cycles spent in the statistics clear.
    localparam logic [3:0] STATS_CLEAR_CYCLES = 4'h4;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FLUSH,
        ST_STATS,
        ST_FETCH,
        ST_FINISH
    } scc_state_type;

endpackage : scc_pkg

// [logic/scc_ctrl.sv]
// Security-context cache control, status and ingress default routing.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module scc_ctrl
    import scc_pkg::*;
#(
    parameter int ENTRIES = 16
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic arst_n,
    // Avalon-MM register slave.
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Ingress ports, index 0 is port zero.
    input wire logic [1:0] inValid,
    input wire logic [1:0] inDefaultSel,
    input wire logic [1:0][ENG_W-1:0] inEngine,
    input wire logic [1:0][SCID_W-1:0] inScId,
    // Routed packet result.
    output logic [1:0] outValid,
    output logic [1:0][FLOW_W-1:0] outFlow,
    output logic [1:0][ENG_W-1:0] outEngine,
    output logic [1:0] outLookup,
    output logic [1:0] outHit,
    // Context fetch from host memory.
    output logic fetchReq,
    output logic [31:0] fetchAddr,
    output logic [SCID_W-1:0] fetchScId,
    output logic fetchAuto,
    input wire logic fetchAck,
    input wire logic fetchOwnerHost
);

    localparam int IDX_W = $clog2(ENTRIES);

    if (ENTRIES < 2 || ENTRIES > 64) begin : gChk
        $error("ENTRIES must lie between 2 and 64");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    scc_state_type state_ff;
    logic [3:0] walk_ff;
    logic [IDX_W-1:0] flushIdx_ff;
    logic [ENTRIES-1:0] entValid_ff;
    logic [SCID_W-1:0] entId_ff [ENTRIES];
    logic [IDX_W-1:0] rr_ff;
    logic p0En_ff, p1En_ff, autoEn_ff;
    logic flushBit_ff, statsBit_ff, goBit_ff;
    logic [31:0] ptr_ff;
    logic [1:0][FLOW_W-1:0] flow_ff;
    logic [1:0][ENG_W-1:0] eng_ff;
    logic [31:0] missCnt_ff;
    logic done_ff;
    logic [2:0] err_ff;
    logic [RAMIDX_W-1:0] ramIdx_ff;
    logic tear_ff, evict_ff;
    logic [SCID_W-1:0] scId_ff;
    logic [CNT_W-1:0] ctxCount_ff;
    logic waitReq_ff;
    logic [31:0] rdData_ff;
    logic [1:0] outValid_ff, outLookup_ff, outHit_ff;
    logic [1:0][FLOW_W-1:0] outFlow_ff;
    logic [1:0][ENG_W-1:0] outEngine_ff;
    logic fetchReq_ff, fetchAuto_ff;
    logic [31:0] fetchAddr_ff;
    logic [SCID_W-1:0] fetchScId_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode. A request is answered on the cycle after it is seen, so
    // every access costs exactly two edges and the read mux stays registered.
    logic accept, wrEn;
    logic [4:0] wordAddr;
    logic [31:0] beMask;
    logic idle;
    logic wrCtrl, wrId;
    logic cmdFlush, cmdStats, cmdOp;

    assign accept = (avs_read | avs_write) & ~waitReq_ff;
    assign wrEn = avs_write & accept;
    assign wordAddr = {avs_address[4:2], 2'b00};
    assign beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign idle = (state_ff == ST_IDLE);
    assign wrCtrl = wrEn & (wordAddr == OFS_CTRL) & avs_byteenable[0];
    assign wrId = wrEn & (wordAddr == OFS_ID);
    // Commands written while busy are dropped rather than queued.
    assign cmdFlush = wrCtrl & idle & avs_writedata[CTRL_FLUSH_BIT];
    assign cmdStats = wrCtrl & idle & avs_writedata[CTRL_STATS_BIT];
    assign cmdOp = wrId & idle & avs_byteenable[2] & avs_writedata[ID_GO_BIT];

    function automatic logic [31:0] merge(input logic [31:0] oldV,
                                          input logic [31:0] newV,
                                          input logic [31:0] m);
        merge = (oldV & ~m) | (newV & m);
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////
    // Cache lookups: one per ingress port and one for register commands.
    logic [1:0] hit, miss, portEn;
    logic [1:0][SCID_W-1:0] lkId;
    logic regHit;
    logic [IDX_W-1:0] regHitIdx;
    logic [IDX_W-1:0] victim;
    logic haveFree;

    assign portEn = {p1En_ff, p0En_ff};

    for (genvar p = 0; p < 2; p++) begin : gPort
        always_comb begin
            hit[p] = 1'b0;
            for (int e = 0; e < ENTRIES; e++) begin
                if (entValid_ff[e] && entId_ff[e] == inScId[p]) begin
                    hit[p] = 1'b1;
                end
            end
        end
        assign lkId[p] = inScId[p];
        // A disabled port gets no lookup and so can never miss.
        assign miss[p] = inValid[p] & portEn[p] & ~hit[p];

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                outValid_ff[p] <= 1'b0;
                outLookup_ff[p] <= 1'b0;
                outHit_ff[p] <= 1'b0;
                outFlow_ff[p] <= RST_FLOW;
                outEngine_ff[p] <= RST_ENG1;
            end else begin
                outValid_ff[p] <= inValid[p];
                outLookup_ff[p] <= inValid[p] & portEn[p];
                outHit_ff[p] <= inValid[p] & portEn[p] & hit[p];
                outFlow_ff[p] <= flow_ff[p];
                outEngine_ff[p] <= inDefaultSel[p] ? eng_ff[p] : inEngine[p];
            end
        end
    end

    always_comb begin
        regHit = 1'b0;
        regHitIdx = '0;
        haveFree = 1'b0;
        victim = rr_ff;
        for (int e = ENTRIES - 1; e >= 0; e--) begin
            if (entValid_ff[e] && entId_ff[e] == avs_writedata[SCID_W-1:0]) begin
                regHit = 1'b1;
                regHitIdx = IDX_W'(e);
            end
            if (!entValid_ff[e]) begin
                haveFree = 1'b1;
                victim = IDX_W'(e);
            end
        end
    end

    // Auto-fetch is only started from idle; a miss seen while busy is counted
    // outside the statistics clear but not fetched, the next packet of that context retries it.
    logic autoStart, noAutoMiss;
    logic [SCID_W-1:0] autoId;
    assign autoStart = idle & ~cmdFlush & ~cmdStats & ~cmdOp & autoEn_ff & (|miss);
    assign noAutoMiss = ~autoEn_ff & (|miss);
    assign autoId = miss[0] ? lkId[0] : lkId[1];

    ////////////////////////////////////////////////////////////////////////////
    // Operation sequencer.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_IDLE;
            walk_ff <= 4'h0;
            flushIdx_ff <= '0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    flushIdx_ff <= '0;
                    walk_ff <= 4'h0;
                    if (cmdFlush) begin
                        state_ff <= ST_FLUSH;
                    end else if (cmdStats) begin
                        state_ff <= ST_STATS;
                    end else if (cmdOp) begin
                        if (avs_writedata[ID_TEAR_BIT] || avs_writedata[ID_EVICT_BIT]) begin
                            state_ff <= ST_FINISH;
                        end else begin
                            state_ff <= ST_FETCH;
                        end
                    end else if (autoStart) begin
                        state_ff <= ST_FETCH;
                    end
                end
                ST_FLUSH: begin
                    flushIdx_ff <= flushIdx_ff + IDX_W'(1);
                    if (flushIdx_ff == IDX_W'(ENTRIES - 1)) begin
                        state_ff <= statsBit_ff ? ST_STATS : ST_FINISH;
                    end
                end
                ST_STATS: begin
                    walk_ff <= walk_ff + 4'h1;
                    if (walk_ff == STATS_CLEAR_CYCLES - 4'h1) begin
                        state_ff <= ST_FINISH;
                    end
                end
                ST_FETCH: begin
                    if (fetchAck) begin
                        state_ff <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cache table.
    logic fetchOk;
    assign fetchOk = (state_ff == ST_FETCH) & fetchAck & ~fetchOwnerHost;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            entValid_ff <= '0;
            rr_ff <= '0;
            for (int e = 0; e < ENTRIES; e++) begin
                entId_ff[e] <= '0;
            end
        end else begin
            if (state_ff == ST_FLUSH) begin
                entValid_ff[flushIdx_ff] <= 1'b0;
            end else if (cmdOp && regHit &&
                         (avs_writedata[ID_TEAR_BIT] || avs_writedata[ID_EVICT_BIT])) begin
                entValid_ff[regHitIdx] <= 1'b0;
            end else if (fetchOk) begin
                entValid_ff[victim] <= 1'b1;
                entId_ff[victim] <= fetchScId_ff;
                if (!haveFree) begin
                    // Wrap at the last entry, as the depth need not be a power of two.
                    rr_ff <= (rr_ff == IDX_W'(ENTRIES - 1)) ? '0 : rr_ff + IDX_W'(1);
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctxCount_ff <= '0;
        end else begin
            ctxCount_ff <= CNT_W'($countones(entValid_ff));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fetch request towards host memory, held until acknowledged.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fetchReq_ff <= 1'b0;
            fetchAuto_ff <= 1'b0;
            fetchAddr_ff <= RST_PTR;
            fetchScId_ff <= '0;
        end else if (idle && cmdOp && !avs_writedata[ID_TEAR_BIT] &&
                     !avs_writedata[ID_EVICT_BIT]) begin
            fetchReq_ff <= 1'b1;
            fetchAuto_ff <= 1'b0;
            fetchAddr_ff <= ptr_ff;
            fetchScId_ff <= avs_writedata[SCID_W-1:0];
        end else if (autoStart) begin
            fetchReq_ff <= 1'b1;
            fetchAuto_ff <= 1'b1;
            fetchAddr_ff <= ptr_ff;
            fetchScId_ff <= autoId;
        end else if (fetchAck) begin
            fetchReq_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command bits and operation status.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flushBit_ff <= 1'b0;
            statsBit_ff <= 1'b0;
            goBit_ff <= 1'b0;
            done_ff <= 1'b0;
            err_ff <= ERR_OK;
            ramIdx_ff <= '0;
        end else begin
            if (cmdFlush) begin
                flushBit_ff <= 1'b1;
            end else if (state_ff == ST_FLUSH && flushIdx_ff == IDX_W'(ENTRIES - 1)) begin
                flushBit_ff <= 1'b0;
            end
            if (cmdStats) begin
                statsBit_ff <= 1'b1;
            end else if (state_ff == ST_FINISH) begin
                statsBit_ff <= 1'b0;
            end
            if (cmdOp) begin
                goBit_ff <= 1'b1;
                done_ff <= 1'b0;
                err_ff <= ERR_OK;
                if (avs_writedata[ID_TEAR_BIT] || avs_writedata[ID_EVICT_BIT]) begin
                    ramIdx_ff <= RAMIDX_W'(regHitIdx);
                    if (!regHit) begin
                        err_ff <= avs_writedata[ID_TEAR_BIT] ? ERR_TEAR_MISS
                                                              : ERR_EVICT_MISS;
                    end
                end
            end else if (autoStart) begin
                done_ff <= 1'b0;
                err_ff <= ERR_OK;
            end else if (state_ff == ST_FETCH && fetchAck) begin
                err_ff <= fetchOwnerHost ? ERR_OWNER : ERR_OK;
                ramIdx_ff <= RAMIDX_W'(victim);
            end else if (state_ff == ST_FINISH) begin
                goBit_ff <= 1'b0;
                if (!flushBit_ff && !statsBit_ff) begin
                    done_ff <= 1'b1;
                end
            end else if (idle && noAutoMiss) begin
                err_ff <= ERR_NO_AUTO;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Miss counter. The clear holds it at zero while it runs, so misses in
    // that window are not counted.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            missCnt_ff <= 32'h0000_0000;
        end else if (state_ff == ST_STATS) begin
            missCnt_ff <= 32'h0000_0000;
        end else begin
            missCnt_ff <= missCnt_ff + 32'(miss[0]) + 32'(miss[1]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-written configuration.
    logic [31:0] wPtr, wFlow1, wFlow0, wEng1, wEng0, wId;
    assign wPtr = merge(ptr_ff, avs_writedata, beMask);
    assign wFlow1 = merge({24'h000000, flow_ff[1]}, avs_writedata, beMask);
    assign wFlow0 = merge({24'h000000, flow_ff[0]}, avs_writedata, beMask);
    assign wEng1 = merge({27'h0000000, eng_ff[1]}, avs_writedata, beMask);
    assign wEng0 = merge({27'h0000000, eng_ff[0]}, avs_writedata, beMask);
    assign wId = merge({14'h0000, tear_ff, evict_ff, scId_ff}, avs_writedata, beMask);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            p0En_ff <= RST_P0EN;
            p1En_ff <= RST_P1EN;
            autoEn_ff <= RST_AUTO;
            ptr_ff <= RST_PTR;
            flow_ff <= {RST_FLOW, RST_FLOW};
            eng_ff <= {RST_ENG1, RST_ENG0};
            tear_ff <= 1'b0;
            evict_ff <= 1'b0;
            scId_ff <= '0;
        end else if (wrEn) begin
            case (wordAddr)
                OFS_CTRL: begin
                    if (avs_byteenable[0]) begin
                        p0En_ff <= avs_writedata[CTRL_P0EN_BIT];
                        p1En_ff <= avs_writedata[CTRL_P1EN_BIT];
                        autoEn_ff <= avs_writedata[CTRL_AUTO_BIT];
                    end
                end
                OFS_PTR: ptr_ff <= wPtr;
                OFS_FLOW1: flow_ff[1] <= wFlow1[FLOW_W-1:0];
                OFS_FLOW0: flow_ff[0] <= wFlow0[FLOW_W-1:0];
                OFS_ENG1: eng_ff[1] <= wEng1[ENG_W-1:0];
                OFS_ENG0: eng_ff[0] <= wEng0[ENG_W-1:0];
                OFS_ID: begin
                    tear_ff <= wId[ID_TEAR_BIT];
                    evict_ff <= wId[ID_EVICT_BIT];
                    scId_ff <= wId[SCID_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux and answer timing.
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        case (wordAddr)
            OFS_CTRL: begin
                rdMux[CTRL_BUSY_BIT] = ~idle;
                rdMux[CTRL_CNT_LSB +: CNT_W] = ctxCount_ff;
                rdMux[CTRL_STATS_BIT] = statsBit_ff;
                rdMux[CTRL_P0EN_BIT] = p0En_ff;
                rdMux[CTRL_P1EN_BIT] = p1En_ff;
                rdMux[CTRL_FLUSH_BIT] = flushBit_ff;
                rdMux[CTRL_AUTO_BIT] = autoEn_ff;
            end
            OFS_PTR: rdMux = ptr_ff;
            OFS_ID: begin
                rdMux[ID_DONE_BIT] = done_ff;
                rdMux[ID_ERR_LSB +: 3] = err_ff;
                rdMux[ID_RAM_LSB +: RAMIDX_W] = ramIdx_ff;
                rdMux[ID_GO_BIT] = goBit_ff;
                rdMux[ID_TEAR_BIT] = tear_ff;
                rdMux[ID_EVICT_BIT] = evict_ff;
                rdMux[SCID_W-1:0] = scId_ff;
            end
            OFS_MISS: rdMux = missCnt_ff;
            OFS_FLOW1: rdMux[FLOW_W-1:0] = flow_ff[1];
            OFS_FLOW0: rdMux[FLOW_W-1:0] = flow_ff[0];
            OFS_ENG1: rdMux[ENG_W-1:0] = eng_ff[1];
            OFS_ENG0: rdMux[ENG_W-1:0] = eng_ff[0];
            default: rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            waitReq_ff <= 1'b1;
            rdData_ff <= 32'h0000_0000;
        end else if (waitReq_ff && (avs_read || avs_write)) begin
            waitReq_ff <= 1'b0;
            rdData_ff <= avs_read ? rdMux : 32'h0000_0000;
        end else begin
            waitReq_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign avs_readdata = rdData_ff;
    assign avs_waitrequest = waitReq_ff;
    assign outValid = outValid_ff;
    assign outFlow = outFlow_ff;
    assign outEngine = outEngine_ff;
    assign outLookup = outLookup_ff;
    assign outHit = outHit_ff;
    assign fetchReq = fetchReq_ff;
    assign fetchAddr = fetchAddr_ff;
    assign fetchScId = fetchScId_ff;
    assign fetchAuto = fetchAuto_ff;

endmodule : scc_ctrl

// [bench/scc_checker.sv]
// Port assertions for the context cache controller.
`timescale 1ns/1ps
module scc_checker (
    // Watched ports.
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [1:0] inValid,
    input wire logic [1:0] outValid,
    input wire logic [1:0] outLookup,
    input wire logic [1:0] outHit,
    input wire logic fetchReq,
    input wire logic fetchAck
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_p0_result: assert property (inValid[0] |=> outValid[0]) else $error("late");
    a_p1_cause: assert property (outValid[1] |-> $past(inValid[1])) else $error("stray");
    a_p1_pulse: assert property (inValid[1] ##1 !inValid[1] |=> !outValid[1]) else $error("long");
    a_hit_lookup: assert property (outHit[0] |-> outLookup[0]) else $error("hit");
    a_lookup_valid: assert property (outLookup[1] |-> outValid[1]) else $error("lookup");
    a_fetch_hold: assert property (fetchReq && !fetchAck |=> fetchReq) else $error("drop");
    a_fetch_end: assert property (fetchAck |=> !fetchReq) else $error("hold");
    a_fetch_fall: assert property ($fell(fetchReq) |-> $past(fetchAck)) else $error("fall");
endmodule : scc_checker
////////////////////////////////////////////////////////////////////////////////
bind scc_ctrl scc_checker chk (.*);

// [bench/scc_fetch_model.sv]
// Host-memory fetch responder with a bench-chosen latency.
`timescale 1ns/1ps
module scc_fetch_model (
    // Bench control and fetch handshake.
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ownerBad,
    input wire logic [1:0] lat,
    input wire logic fetchReq,
    output logic fetchAck,
    output logic fetchOwnerHost
);
    logic [1:0] cnt_ff;
    logic ack_ff;
    assign fetchAck = ack_ff;
    // Outside an ack the owner line shows the inverse, so a stale sample cannot pass.
    assign fetchOwnerHost = ack_ff ? ownerBad : !ownerBad;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) {ack_ff, cnt_ff} <= 3'h0;
        else begin
            ack_ff <= fetchReq && !ack_ff && cnt_ff == lat;
            cnt_ff <= (fetchReq && !ack_ff && cnt_ff != lat) ? cnt_ff + 2'h1 : 2'h0;
        end
    end
endmodule : scc_fetch_model

// [bench/tb_top.sv]
// Self-checking bench for the context cache controller.
`timescale 1ns/1ps
module tb_top import scc_pkg::*;;
    logic clk_sys = 1'h0, arst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0, ownerBad = 1'h0;
    logic avs_waitrequest, fetchReq, fetchAuto, fetchAck, fetchOwnerHost;
    logic [1:0] inValid = 2'h0, inDefaultSel = 2'h0, outValid, outLookup, outHit, lat = 2'h0;
    logic [4:0] avs_address = 5'h00;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, fetchAddr, rdat, s = 32'h14F1C, got;
    logic [1:0][ENG_W-1:0] inEngine = '0, outEngine;
    logic [1:0][SCID_W-1:0] inScId = '0;
    logic [1:0][FLOW_W-1:0] outFlow;
    logic [SCID_W-1:0] fetchScId;
    logic [63:0] q[$], pq[$], fq[$], e;
    logic [31:0] op[5] = '{32'h80123, 32'h80456, 32'h90777, 32'hA0777, 32'h90123};
    logic [31:0] oe[5] = '{32'h80000000, 32'hC0000000, 32'hA0000000, 32'hB0000000, 32'h80000000};
    int errCount = 0, comparisons = 0, cyc = 0;
    scc_ctrl #(.ENTRIES(4)) DUT (.*);
    scc_fetch_model fm (.*);
    always #20 clk_sys = !clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            errCount++;
            $display("BAD %0t %h not %h", $time, seen, want);
        end
    endtask : check
    task automatic giveVerdict();
        $display("checks %0d bad %0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : giveVerdict
    // A read notes its expectation and mask; a zero mask marks a poll that is not compared.
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d, m);
        if (!w) q.push_back({m, d});
        {avs_address, avs_writedata, avs_read, avs_write} <= {a, d, !w, w};
        do @(posedge clk_sys); while (avs_waitrequest);
        rdat = avs_readdata;
        {avs_read, avs_write} <= 2'h0;
        @(posedge clk_sys);
    endtask : acc
    // A packet notes its expected result; the monitor compares it when outValid shows.
    task automatic pkt(input int p, input logic sel, input logic [15:0] id, input logic [14:0] x);
        pq.push_back({48'h0, 1'(p), x[14:7], sel ? x[6:2] : s[4:0], x[1:0]});
        {inValid[p], inDefaultSel[p], inEngine[p], inScId[p]} <= {1'h1, sel, s[4:0], id};
        @(posedge clk_sys);
        inValid[p] <= 1'h0;
        @(posedge clk_sys);
    endtask : pkt
    always @(posedge clk_sys) begin
        cyc++;
        if (avs_read && !avs_waitrequest) begin
            e = q.pop_front();
            if (e[63:32] != 32'h0) check(avs_readdata & e[63:32], e[31:0]);
        end
        for (int p = 0; p < 2; p++) begin
            if (outValid[p]) begin
                e = pq.pop_front();
                got = {16'h0, 1'(p), outFlow[p], outEngine[p], outLookup[p], outHit[p]};
                check(got, e[31:0]);
            end
        end
        if (fetchAck) begin
            e = fq.pop_front();
            check({15'h0, fetchAuto, fetchScId}, e[63:32]);
            check(fetchAddr, e[31:0]);
        end
        if (cyc == 20000) begin
            errCount++;
            giveVerdict();
        end
    end
    initial begin
        logic [7:0] f1;
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'h1;
        @(posedge clk_sys);
        for (int i = 0; i < 8; i++) acc(0, 5'(i * 4), i == 0 ? 32'hD : i == 7 ? 32'h8 : 32'h0, '1);
        f1 = s[7:0];
        acc(1, OFS_FLOW1, s, '0);
        acc(0, OFS_FLOW1, {24'h0, f1}, '1);
        s = lfsr(s);
        acc(1, OFS_FLOW0, s, '0);
        acc(1, OFS_ENG1, 32'h8, '0);
        acc(1, OFS_ENG0, 32'h0, '0);
        fq.push_back({15'h0, 1'h1, 16'h5, 32'h0});
        pkt(0, 1, 16'h5, {s[7:0], 5'h0, 2'h2});
        do acc(0, OFS_CTRL, '0, '0); while (rdat[31]);
        acc(0, OFS_CTRL, 32'h0100000D, '1);
        pkt(1, 1, 16'h5, {f1, 5'h8, 2'h3});
        acc(0, OFS_MISS, 32'h1, '1);
        acc(1, OFS_CTRL, 32'h1, '0);
        pkt(0, 0, 16'h6, {s[7:0], 5'h0, 2'h0});
        pkt(1, 0, 16'h6, {f1, 5'h8, 2'h0});
        $display("routing tests done");
        acc(1, OFS_PTR, s, '0);
        for (int i = 0; i < 5; i++) begin
            {ownerBad, lat} <= {i == 1, s[2 * i +: 2]};
            if (op[i][17:16] == 2'h0) fq.push_back({15'h0, 1'h0, op[i][15:0], s});
            acc(1, OFS_ID, op[i], '0);
            do acc(0, OFS_ID, '0, '0); while (!rdat[31]);
            check(rdat & 32'hF0080000, oe[i]);
        end
        acc(0, OFS_CTRL, 32'h01000001, '1);
        acc(1, OFS_CTRL, 32'hC, '0);
        pkt(1, 1, 16'h999, {f1, 5'h8, 2'h2});
        acc(0, OFS_ID, 32'h60000000, 32'h70000000);
        acc(0, OFS_MISS, 32'h2, '1);
        $display("command tests done");
        for (int k = 0; k < 2; k++) begin
            acc(1, OFS_CTRL, k ? 32'hE : 32'h1C, '0);
            acc(0, OFS_CTRL, k ? 32'h80000002 : 32'h80000010, 32'h80000012);
            do acc(0, OFS_CTRL, '0, '0); while (rdat[31]);
        end
        acc(0, OFS_MISS, 32'h0, '1);
        acc(0, OFS_CTRL, 32'hC, '1);
        $display("clear tests done");
        check(32'(q.size() + pq.size() + fq.size()), 32'h0);
        giveVerdict();
    end
endmodule : tb_top
